// File: rtl/arf_top.sv
// Purpose: Conversion start, result FIFO and APB registers of the analog input path
// Assumes: Pins and ADC data are asynchronous and pass two flip-flops
// Notes: Reads complete with one wait state, ROM data one cycle after setup
`timescale 1ns/1ps
`include "arf_regs.svh"
module arf_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [19:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [12:0] rom_addr,
   input wire logic [7:0] rom_data,
   input wire logic sample_timer_output,
   input wire logic sample_count_output,
   input wire logic ext_convert_n,
   input wire logic [11:0] adc_result,
   output logic adc_start,
   output logic [2:0] channel_select,
   output logic [2:0] gain_select,
   output logic timebase_select
);
   arf_fifo_if fif ();

   arf_fifo u_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .fif(fif)
   );

   // Pin synchronisers
   logic tmr_s1;
   logic tmr_s2;
   logic tmr_d;
   logic cnt_s1;
   logic cnt_s2;
   logic ext_s1;
   logic ext_s2;
   logic ext_d;
   logic [11:0] res_s1;
   logic [11:0] res_s2;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tmr_s1 <= 1'b1;
         tmr_s2 <= 1'b1;
         tmr_d <= 1'b1;
         cnt_s1 <= 1'b1;
         cnt_s2 <= 1'b1;
         ext_s1 <= 1'b1;
         ext_s2 <= 1'b1;
         ext_d <= 1'b1;
         res_s1 <= 12'h000;
         res_s2 <= 12'h000;
      end
      else
      begin
         tmr_s1 <= sample_timer_output;
         tmr_s2 <= tmr_s1;
         tmr_d <= tmr_s2;
         cnt_s1 <= sample_count_output;
         cnt_s2 <= cnt_s1;
         ext_s1 <= ext_convert_n;
         ext_s2 <= ext_s1;
         ext_d <= ext_s2;
         res_s1 <= adc_result;
         res_s2 <= res_s1;
      end
   end

   logic tmr_fall;
   logic tmr_rise;
   logic ext_fall;
   logic ext_rise;

   assign tmr_fall = tmr_d & ~tmr_s2;
   assign tmr_rise = ~tmr_d & tmr_s2;
   assign ext_fall = ext_d & ~ext_s2;
   assign ext_rise = ~ext_d & ext_s2;

   // APB decode
   logic setup;
   logic capture;
   logic done;
   logic is_status;
   logic is_fifo;
   logic is_config;
   logic is_clear;
   logic is_rom;
   logic mapped;

   assign setup = psel & ~penable;
   assign capture = psel & penable & ~pready;
   assign done = psel & penable & pready;
   assign is_status = (paddr == `ARF_STATUS_OFS);
   assign is_fifo = (paddr == `ARF_FIFO_OFS);
   assign is_config = (paddr == `ARF_CONFIG_OFS);
   assign is_clear = (paddr == `ARF_CLEAR_OFS);
   assign is_rom = (paddr >= `ARF_ROM_FIRST) && (paddr <= `ARF_ROM_LAST)
                   && (paddr[1:0] == 2'b00);
   assign mapped = pwrite ? (is_config | is_clear | is_status | is_fifo)
                          : (is_status | is_fifo | is_rom);

   logic [15:0] cfg;
   logic clr_req;
   logic wr_cfg;

   assign wr_cfg = done & pwrite & is_config;
   assign clr_req = done & pwrite & is_clear;

   // Configuration is write-only; every bit is replaced on each write
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cfg <= `ARF_CFG_RESET;
      else if (wr_cfg)
         cfg <= pwdata[15:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         channel_select <= 3'h0;
         gain_select <= 3'h0;
         timebase_select <= 1'b0;
      end
      else
      begin
         channel_select <= cfg[`ARF_CFG_CHAN_LSB +: 3];
         gain_select <= cfg[`ARF_CFG_GAIN_LSB +: 3];
         timebase_select <= cfg[`ARF_CFG_TBSEL];
      end
   end

   // Conversion sequencing
   arf_pkg::arf_state_t state;
   logic [10:0] timer;
   logic src_ext;
   logic rise_seen;
   logic src_rise;
   logic start_req;
   logic push_now;

   assign src_rise = src_ext ? ext_rise : tmr_rise;
   assign start_req = tmr_fall | ext_fall;
   assign push_now = ((state == arf_pkg::ARF_CONV) && (timer == 11'h000)
                      && (rise_seen || src_rise))
                     || ((state == arf_pkg::ARF_HOLD) && src_rise);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= arf_pkg::ARF_IDLE;
         timer <= 11'h000;
         src_ext <= 1'b0;
         rise_seen <= 1'b0;
      end
      else
      begin
         case (state)
            arf_pkg::ARF_IDLE:
            begin
               if (start_req)
               begin
                  src_ext <= ext_fall & ~tmr_fall;
                  timer <= 11'(`ARF_CONV_CYCLES - 1);
                  rise_seen <= 1'b0;
                  state <= arf_pkg::ARF_CONV;
               end
            end
            arf_pkg::ARF_CONV:
            begin
               if (src_rise)
                  rise_seen <= 1'b1;
               if (timer != 11'h000)
                  timer <= timer - 11'h001;
               else if (push_now)
                  state <= arf_pkg::ARF_IDLE;
               else
                  state <= arf_pkg::ARF_HOLD;
            end
            arf_pkg::ARF_HOLD:
            begin
               if (push_now)
                  state <= arf_pkg::ARF_IDLE;
            end
            default:
               state <= arf_pkg::ARF_IDLE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         adc_start <= 1'b0;
      else
         adc_start <= (state == arf_pkg::ARF_IDLE) && start_req;
   end

   // FIFO traffic
   logic rd_pop;

   assign rd_pop = capture & ~pwrite & is_fifo;
   assign fif.push = push_now;
   assign fif.push_data = res_s2;
   assign fif.pop = rd_pop;
   assign fif.clear = clr_req;

   // Error flags; a new event wins over a clear in the same cycle
   logic overflow;
   logic overrun;
   logic set_ovf;
   logic set_ovr;

   assign set_ovf = push_now & fif.full;
   assign set_ovr = start_req & (state != arf_pkg::ARF_IDLE);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         overflow <= 1'b0;
      else if (set_ovf)
         overflow <= 1'b1;
      else if (clr_req)
         overflow <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         overrun <= 1'b0;
      else if (set_ovr)
         overrun <= 1'b1;
      else if (clr_req)
         overrun <= 1'b0;
   end

   // Output format of the head entry
   logic [15:0] fifo_word;

   always_comb
   begin
      if (cfg[`ARF_CFG_SIGNED])
         fifo_word = {{5{~fif.pop_data[11]}}, fif.pop_data[10:0]};
      else
         fifo_word = {4'h0, fif.pop_data};
   end

   logic [31:0] status_word;

   assign status_word = {27'h0000000, cnt_s2, state != arf_pkg::ARF_IDLE,
                         overrun, overflow, ~fif.empty};

   // APB answer: pready rises one cycle into the access phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pready <= 1'b0;
      else
         pready <= capture;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rom_addr <= 13'h0000;
      else if (setup && is_rom)
         rom_addr <= paddr[14:2];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end
      else if (capture)
      begin
         pslverr <= ~mapped;
         if (pwrite || !mapped)
            prdata <= 32'h00000000;
         else if (is_status)
            prdata <= status_word;
         else if (is_fifo)
            prdata <= {16'h0000, fifo_word};
         else
            prdata <= {24'h000000, rom_data};
      end
      else if (done)
      begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end
   end
endmodule : arf_top

// File: pkg/arf_regs.svh
// Purpose: Register map, field positions and timing counts for the result FIFO control
// Assumes: 100 MHz pclk, APB with 32-bit data, byte addresses
// Notes: Included by the design files by bare name
// How it works
// - byte-wide 8 KB ROM, one byte per word
// - control writes update all bits, no readback
// - timer or external falling edge starts conversion
// - push at later of end and rise
// - status bit 0 shows FIFO not empty
// - timer start: flag after 12 us and rise
// - external start: flag after delay and rise
// - FIFO read returns oldest and removes it
// - push beyond 16 results sets overflow flag
// - clear write resets error flags and FIFO
// - after clear FIFO holds one garbage word
// - signed select chooses two's complement output
// - straight binary gives 0000 to 0FFF
// - two's complement gives F800 to 07FF
// - zero configuration gives gain 1, channel 0
`ifndef ARF_REGS_SVH
`define ARF_REGS_SVH
`define ARF_ADDR_W 20
`define ARF_STATUS_OFS 20'h00000
`define ARF_FIFO_OFS 20'h00004
`define ARF_CONFIG_OFS 20'h00008
`define ARF_CLEAR_OFS 20'h0000C
`define ARF_ROM_FIRST 20'hF8000
`define ARF_ROM_LAST 20'hFFFFC
`define ARF_ST_AVAIL 0
`define ARF_ST_OVERFLOW 1
`define ARF_ST_OVERRUN 2
`define ARF_ST_BUSY 3
`define ARF_ST_COUNT_OUT 4
`define ARF_CFG_CHAN_LSB 0
`define ARF_CFG_GAIN_LSB 4
`define ARF_CFG_TBSEL 7
`define ARF_CFG_SIGNED 8
`define ARF_CFG_RESET 16'h0000
`define ARF_RESULT_W 12
`define ARF_FIFO_DEPTH 16
`define ARF_GARBAGE 12'h000
`define ARF_CLK_NS 10
`define ARF_CONV_TIME_NS 12000
`define ARF_CONV_CYCLES ((`ARF_CONV_TIME_NS + `ARF_CLK_NS - 1) / `ARF_CLK_NS)
`endif

// File: pkg/arf_pkg.sv
// Purpose: Types shared by the result FIFO control
// Assumes: Nothing
// Notes: One-hot conversion states
package arf_pkg;
   typedef enum logic [2:0] {
      ARF_IDLE = 3'b001,
      ARF_CONV = 3'b010,
      ARF_HOLD = 3'b100
   } arf_state_t;
   typedef logic [11:0] arf_result_t;
endpackage : arf_pkg

// File: pkg/arf_fifo_if.sv
// Purpose: Signals between the controller and the result store
// Assumes: Both ends on pclk
// Notes: ctrl drives push, pop and clear
`timescale 1ns/1ps
interface arf_fifo_if;
   logic push;
   logic pop;
   logic clear;
   arf_pkg::arf_result_t push_data;
   arf_pkg::arf_result_t pop_data;
   logic empty;
   logic full;
   modport ctrl (output push, output pop, output clear, output push_data,
                 input pop_data, input empty, input full);
   modport store (input push, input pop, input clear, input push_data,
                  output pop_data, output empty, output full);
endinterface : arf_fifo_if

// File: rtl/arf_fifo.sv
// Purpose: Sixteen-entry result store in flip-flops
// Assumes: Pop on empty and push on full are ignored
// Notes: Clear leaves a single garbage word
`timescale 1ns/1ps
`include "arf_regs.svh"
module arf_fifo (
   input wire logic pclk,
   input wire logic presetn,
   arf_fifo_if.store fif
);
   arf_pkg::arf_result_t mem [`ARF_FIFO_DEPTH];
   logic [3:0] wr_ptr;
   logic [3:0] rd_ptr;
   logic [4:0] count;
   logic do_push;
   logic do_pop;

   assign do_push = fif.push & ~fif.full;
   assign do_pop = fif.pop & ~fif.empty;
   assign fif.empty = (count == 5'h00);
   assign fif.full = (count == 5'h10);
   assign fif.pop_data = mem[rd_ptr];

   genvar i;
   generate
      for (i = 0; i < `ARF_FIFO_DEPTH; i++)
      begin : g_entry
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               mem[i] <= 12'h000;
            else if (fif.clear && i == 0)
               mem[i] <= `ARF_GARBAGE;
            else if (!fif.clear && do_push && wr_ptr == 4'(i))
               mem[i] <= fif.push_data;
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wr_ptr <= 4'h0;
         rd_ptr <= 4'h0;
         count <= 5'h00;
      end
      else if (fif.clear)
      begin
         wr_ptr <= 4'h1;
         rd_ptr <= 4'h0;
         count <= 5'h01;
      end
      else
      begin
         if (do_push)
            wr_ptr <= wr_ptr + 4'h1;
         if (do_pop)
            rd_ptr <= rd_ptr + 4'h1;
         count <= count + {4'h0, do_push} - {4'h0, do_pop};
      end
   end
endmodule : arf_fifo

// File: testbench/arf_top_sva.sv
// Purpose: Port checker for the result FIFO control
// Assumes: One wait state on every APB transfer
// Notes: Bound to arf_top
`timescale 1ns/1ps
module arf_top_sva (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [19:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [12:0] rom_addr,
   input wire logic adc_start,
   input wire logic [2:0] channel_select
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable;
   endsequence
   a_ready_timing: assert property (s_setup ##1 s_access |=> pready)
      else $error("ready not in second access cycle");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_cfg_noread: assert property (pready && !pwrite && paddr == 20'h00008 |-> pslverr)
      else $error("config readable");
   a_start_gap: assert property (adc_start |=> !adc_start [*8])
      else $error("start pulses too close");
   a_rom_index: assert property (psel && !penable && paddr[19:15] == 5'h1F
      && paddr[1:0] == 2'b00 |=> rom_addr == $past(paddr[14:2]))
      else $error("rom index wrong");
   a_cfg_follow: assert property (pready && pwrite && paddr == 20'h00008 |->
      ##2 channel_select == $past(pwdata[2:0], 2))
      else $error("channel not updated");
endmodule : arf_top_sva
bind arf_top arf_top_sva arf_top_sva_inst (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .pslverr, .rom_addr, .adc_start, .channel_select);

// File: testbench/arf_far_model.sv
// Purpose: Byte-wide configuration ROM beside the block
// Assumes: Asynchronous read
// Notes: Content is a fixed pattern of the index
`timescale 1ns/1ps
module arf_far_model (
   input wire logic [12:0] rom_addr,
   output logic [7:0] rom_data
);
   assign rom_data = rom_addr[7:0] ^ 8'hA5;
endmodule : arf_far_model

// File: testbench/arf_top_bench.sv
// Purpose: Self-checking bench of the result FIFO control
// Assumes: 1200-cycle conversion, pins high when idle
// Notes: APB master waits for pready under a bound
`timescale 1ns/1ps
module arf_top_bench;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [19:0] paddr = 20'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, er, adc_start, timebase_select;
   logic [12:0] rom_addr;
   logic [7:0] rom_data;
   logic tmr = 1, cnt = 1, extn = 1;
   logic [11:0] adc = 12'h0;
   logic [2:0] channel_select, gain_select;
   int err_total = 0, checks_done = 0;
   arf_top arf_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rom_addr(rom_addr), .rom_data(rom_data),
      .sample_timer_output(tmr), .sample_count_output(cnt), .ext_convert_n(extn),
      .adc_result(adc), .adc_start(adc_start), .channel_select(channel_select),
      .gain_select(gain_select), .timebase_select(timebase_select));
   arf_far_model arf_far_model_inst (.rom_addr(rom_addr), .rom_data(rom_data));
   initial
   begin
      forever #5 pclk = ~pclk;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
         err_total++;
      end
   endtask : chk
   task apb(input logic w, input logic [19:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      if (n >= 50)
         chk(32'h0, 32'h1);
   endtask : apb
   task conv(input bit ext, input logic [11:0] v);
      @(posedge pclk);
      adc <= v;
      if (ext)
         extn <= 0;
      else
         tmr <= 0;
      repeat (5) @(posedge pclk);
      tmr <= 1;
      extn <= 1;
      repeat (1215) @(posedge pclk);
   endtask : conv
   task t_regs;
      apb(0, 20'h00000, 0); chk(rd, 32'h10);
      apb(0, 20'h00008, 0); chk(er, 1);
      apb(0, 20'h00010, 0); chk(er, 1);
      apb(0, 20'hF8004, 0); chk(rd, 32'hA4);
      apb(1, 20'hF8004, 1); chk(er, 1);
      apb(1, 20'h00008, 32'hF5); repeat (3) @(posedge pclk);
      chk({channel_select, gain_select, timebase_select}, 7'h5F);
      apb(1, 20'h00008, 0); repeat (3) @(posedge pclk);
      chk({channel_select, gain_select, timebase_select}, 7'h0);
      $display("test regs done");
   endtask : t_regs
   task t_formats;
      conv(0, 12'hFFF);
      apb(0, 20'h00000, 0); chk(rd, 32'h11);
      apb(0, 20'h00004, 0); chk(rd, 32'hFFF);
      apb(0, 20'h00000, 0); chk(rd, 32'h10);
      apb(1, 20'h00008, 32'h100);
      conv(1, 12'h000);
      conv(1, 12'hFFF);
      apb(0, 20'h00000, 0); chk(rd, 32'h11);
      apb(0, 20'h00004, 0); chk(rd, 32'hF800);
      apb(0, 20'h00004, 0); chk(rd, 32'h07FF);
      apb(1, 20'h00008, 0);
      $display("test formats done");
   endtask : t_formats
   // Start edge held low past the conversion time, so the push waits for the rise
   task t_late(input bit ext, input logic [11:0] v);
      @(posedge pclk);
      adc <= v;
      if (ext)
         extn <= 0;
      else
         tmr <= 0;
      repeat (1300) @(posedge pclk);
      apb(0, 20'h00000, 0); chk(rd, 32'h18);
      tmr <= 1;
      extn <= 1;
      repeat (10) @(posedge pclk);
      apb(0, 20'h00000, 0); chk(rd, 32'h11);
      apb(0, 20'h00004, 0); chk(rd, {20'h00000, v});
      $display("test late rise done");
   endtask : t_late
   task t_overflow;
      for (int i = 0; i < 17; i++)
         conv(i[0], 12'h100 + 12'(i));
      apb(0, 20'h00000, 0); chk(rd, 32'h13);
      apb(0, 20'h00004, 0); chk(rd, 32'h100);
      apb(1, 20'h0000C, 0);
      apb(0, 20'h00000, 0); chk(rd, 32'h11);
      apb(0, 20'h00004, 0); chk(rd, 32'h0);
      apb(0, 20'h00000, 0); chk(rd, 32'h10);
      $display("test overflow done");
   endtask : t_overflow
   task tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish
   initial
   begin
      #400000;
      err_total++;
      tally_and_finish();
   end
   initial
   begin
      repeat (16) @(posedge pclk);
      presetn <= 1;
      repeat (4) @(posedge pclk);
      chk({adc_start, channel_select, gain_select, timebase_select}, 8'h0);
      apb(1, 20'h00008, 0);
      apb(1, 20'h0000C, 0);
      apb(0, 20'h00004, 0); chk(rd, 32'h0);
      t_regs();
      t_formats();
      t_late(0, 12'h123);
      t_late(1, 12'h456);
      t_overflow();
      tally_and_finish();
   end
endmodule : arf_top_bench
